// [verilog/uehc_regs.vh]
// Purpose: constants for the endpoint handshake control block
// Assumes: byte-wide special function register space
// Notes: offsets are register indices on the plain register port
`ifndef UEHC_REGS_VH
`define UEHC_REGS_VH

// register offsets
`define UEHC_EP0_TX_CTRL 8'hEA
`define UEHC_EP12_TX_CTRL 8'hEB
`define UEHC_EP_EN_STALL 8'hEC
`define UEHC_STATUS 8'hE8

// endpoint 0 transmit control fields
`define UEHC_B_EP0_PID 7
`define UEHC_B_EP0_STALL 6
`define UEHC_B_EP0_TXEN 5
`define UEHC_B_EP0_RXEN 4

// endpoint 1/2 transmit control fields
`define UEHC_B_EP12_PID 7
`define UEHC_B_EP_SEL 6
`define UEHC_B_EP12_TXEN 5
`define UEHC_B_FRESUME 4

// enable / stall fields
`define UEHC_B_AUTO_AUTO_STATUS_OUT_REPLY 4
`define UEHC_B_EP2_EN 3
`define UEHC_B_EP1_EN 2
`define UEHC_B_EP2_STALL 1
`define UEHC_B_EP1_STALL 0

// status fields
`define UEHC_B_TX0_DONE 4
`define UEHC_B_RX0_DONE 3
`define UEHC_B_TX12_DONE 2
`define UEHC_B_RESUME 0

// reset values
`define UEHC_RST_BYTE 8'h00
`define UEHC_RST_NIB 4'h0

// token and handshake codes
`define UEHC_TOK_OUT 2'h0
`define UEHC_TOK_IN 2'h1
`define UEHC_TOK_SETUP 2'h2
`define UEHC_HS_NONE 2'h0
`define UEHC_HS_DATA 2'h1
`define UEHC_HS_NAK 2'h2
`define UEHC_HS_STALL 2'h3

`endif

// [verilog/uehc_flag.v]
// Purpose: one sticky flag, hardware set, software clear
// Assumes: set and clear may coincide
// Notes: set wins over clear
`timescale 1ns/100ps
module uehc_flag (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire set,
	input wire clr,
	// state
	output reg flag_q
);

// set has priority so no event is lost
always @(posedge clk) begin
	if (rst) begin
		flag_q <= 1'b0;
	end else if (set) begin
		flag_q <= 1'b1;
	end else if (clr) begin
		flag_q <= 1'b0;
	end
end

endmodule // uehc_flag

// [verilog/uehc_decide.v]
// Purpose: handshake decision for one IN or OUT token
// Assumes: inputs stable in the token cycle
// Notes: purely combinational
`timescale 1ns/100ps
module uehc_decide (
	// conditions
	input wire stall,
	input wire nak,
	input wire auto_ack,
	// answer
	output reg [1:0] hs
);

`include "uehc_regs.vh"

// stall beats nak, auto reply beats nak
always @* begin
	if (stall) begin
		hs = `UEHC_HS_STALL;
	end else if (auto_ack) begin
		hs = `UEHC_HS_DATA;
	end else if (nak) begin
		hs = `UEHC_HS_NAK;
	end else begin
		hs = `UEHC_HS_DATA;
	end
end

endmodule // uehc_decide

// [verilog/uehc_top.v]
// Purpose: endpoint transmit/receive handshake control for a low-speed function
// Assumes: token and ack events come one cycle wide from the packet engine
// Notes: status flags live here; packet engine and transceiver are outside
//        force-resume timing is left to software; there is no hold timer here
//        unmapped writes are ignored and reserved bits read zero
//
// Function
// - endpoint 0 pid bit picks DATA0 or DATA1; hardware never toggles it
// - shared pid bit picks DATA0/DATA1 for endpoints 1/2; software toggles it
// - endpoint 0 stall bit answers every endpoint 0 IN or OUT with STALL
// - SETUP token or reset clears the endpoint 0 stall bit
// - endpoint 0 IN gets NAK when transmit disabled or transmit done set
// - endpoint 0 OUT gets NAK when receive disabled or receive done set
// - two 4-bit transmit byte counts in bits 3..0, cleared by reset
// - select bit gives shared buffer to endpoint 1 (0) or 2 (1)
// - endpoint 2 IN gets NAK while select points at endpoint 1
// - endpoint 1/2 IN gets NAK when shared enable off or shared done set
// - force-resume bit drives K state onto the data lines
// - self-driven resume never sets the resume-detected flag
// - status-out bit auto-answers the OUT status stage of control read
// - endpoint 2 and 1 enable bits, cleared by reset
// - endpoint 2 and 1 stall bits, cleared by reset
// - endpoint 0 transmit done set on host ACK, software clears it
// - endpoint 0 receive done set on accepted packet, software clears it
// - shared transmit done set on host ACK of shared buffer data
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module uehc_top (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	// token from packet engine
	input wire tok_valid,
	input wire [1:0] tok_pid,
	input wire [1:0] tok_ep,
	input wire tok_status_stage,
	// transaction outcome from packet engine
	input wire host_ack_ep0,
	input wire host_ack_ep12,
	input wire rx_ok_ep0,
	input wire bus_activity,
	input wire suspended,
	// answer to packet engine
	output wire [1:0] handshake,
	output wire hs_valid,
	output wire data_pid_data1,
	output wire [3:0] tx_byte_count,
	// line drive for resume
	output wire drive_k,
	// resume status
	output wire resume_detected
);

`include "uehc_regs.vh"

// ************************************
// control registers
// ************************************
// software-owned control bits, one flip-flop each except the two 4-bit transmit byte counts
reg ep0_tx_data_pid_select_q;
reg ep0_force_stall_q;
reg ep0_transmit_enable_q;
reg ep0_receive_enable_q;
reg [3:0] ep0_tx_byte_count_q;
reg ep12_tx_data_pid_select_q;
reg shared_buffer_endpoint_select_q;
reg ep12_transmit_enable_q;
reg force_remote_wakeup_q;
reg [3:0] ep12_tx_byte_count_q;
reg auto_status_out_reply_q;
reg endpoint2_enable_q;
reg endpoint1_enable_q;
reg endpoint2_force_stall_q;
reg endpoint1_force_stall_q;

// hardware-set status flags
wire ep0_tx_done;
wire ep0_rx_done;
wire ep12_tx_done;
wire resume_flag;

// register write decode
wire wr_ctl0 = reg_wr && (reg_addr == `UEHC_EP0_TX_CTRL);
wire wr_ctl1 = reg_wr && (reg_addr == `UEHC_EP12_TX_CTRL);
wire wr_ctl2 = reg_wr && (reg_addr == `UEHC_EP_EN_STALL);
wire wr_stat = reg_wr && (reg_addr == `UEHC_STATUS);
wire setup_seen = tok_valid && (tok_pid == `UEHC_TOK_SETUP);

// status clears: a 0 written to a flag bit clears it, a 1 keeps it
wire clr_tx0 = wr_stat && !reg_wdata[`UEHC_B_TX0_DONE];
wire clr_rx0 = wr_stat && !reg_wdata[`UEHC_B_RX0_DONE];
wire clr_tx12 = wr_stat && !reg_wdata[`UEHC_B_TX12_DONE];
wire clr_res = wr_stat && !reg_wdata[`UEHC_B_RESUME];

// own K drive masks bus activity so a self resume is never flagged
wire resume_seen = bus_activity && suspended && !force_remote_wakeup_q;

// endpoint 0 transmit control
always @(posedge clk) begin
	if (rst) begin
		ep0_tx_data_pid_select_q <= 1'b0;
		ep0_force_stall_q <= 1'b0;
		ep0_transmit_enable_q <= 1'b0;
		ep0_receive_enable_q <= 1'b0;
		ep0_tx_byte_count_q <= `UEHC_RST_NIB;
	end else begin
		if (wr_ctl0) begin
			ep0_tx_data_pid_select_q <= reg_wdata[`UEHC_B_EP0_PID];
			ep0_force_stall_q <= reg_wdata[`UEHC_B_EP0_STALL];
			ep0_transmit_enable_q <= reg_wdata[`UEHC_B_EP0_TXEN];
			ep0_receive_enable_q <= reg_wdata[`UEHC_B_EP0_RXEN];
			ep0_tx_byte_count_q <= reg_wdata[3:0];
		end
		// setup clears stall, wins over write
		if (setup_seen && (tok_ep == 2'h0)) begin
			ep0_force_stall_q <= 1'b0;
		end
	end
end

// endpoint 1/2 transmit control
always @(posedge clk) begin
	if (rst) begin
		ep12_tx_data_pid_select_q <= 1'b0;
		shared_buffer_endpoint_select_q <= 1'b0;
		ep12_transmit_enable_q <= 1'b0;
		force_remote_wakeup_q <= 1'b0;
		ep12_tx_byte_count_q <= `UEHC_RST_NIB;
	end else if (wr_ctl1) begin
		ep12_tx_data_pid_select_q <= reg_wdata[`UEHC_B_EP12_PID];
		shared_buffer_endpoint_select_q <= reg_wdata[`UEHC_B_EP_SEL];
		ep12_transmit_enable_q <= reg_wdata[`UEHC_B_EP12_TXEN];
		force_remote_wakeup_q <= reg_wdata[`UEHC_B_FRESUME];
		ep12_tx_byte_count_q <= reg_wdata[3:0];
	end
end

// enable and stall control
always @(posedge clk) begin
	if (rst) begin
		auto_status_out_reply_q <= 1'b0;
		endpoint2_enable_q <= 1'b0;
		endpoint1_enable_q <= 1'b0;
		endpoint2_force_stall_q <= 1'b0;
		endpoint1_force_stall_q <= 1'b0;
	end else if (wr_ctl2) begin
		// bits 7 to 5 are reserved and not stored
		auto_status_out_reply_q <= reg_wdata[`UEHC_B_AUTO_AUTO_STATUS_OUT_REPLY];
		endpoint2_enable_q <= reg_wdata[`UEHC_B_EP2_EN];
		endpoint1_enable_q <= reg_wdata[`UEHC_B_EP1_EN];
		endpoint2_force_stall_q <= reg_wdata[`UEHC_B_EP2_STALL];
		endpoint1_force_stall_q <= reg_wdata[`UEHC_B_EP1_STALL];
	end
end

// ************************************
// token decision
// ************************************
// token decode
wire is_in = tok_pid == `UEHC_TOK_IN;
wire is_out = tok_pid == `UEHC_TOK_OUT;
wire ep_is0 = tok_ep == 2'h0;
wire ep_is1 = tok_ep == 2'h1;
wire ep_is2 = tok_ep == 2'h2;

// a token is judged in its own cycle from the register state before the edge;
// tokens to endpoint 1/2 OUT or to endpoint 3 fall through to NAK
reg cond_stall;
reg cond_nak;
reg cond_auto;

// per-endpoint stall and nak conditions
always @* begin
	cond_stall = 1'b0;
	cond_nak = 1'b1;
	cond_auto = 1'b0;
	if (ep_is0) begin
		cond_stall = ep0_force_stall_q;
		if (is_in) begin
			cond_nak = !ep0_transmit_enable_q || ep0_tx_done;
		end else begin
			cond_nak = !ep0_receive_enable_q || ep0_rx_done;
			cond_auto = auto_status_out_reply_q && tok_status_stage;
		end
	end else if (ep_is1 && is_in) begin
		cond_stall = endpoint1_force_stall_q;
		cond_nak = !ep12_transmit_enable_q || ep12_tx_done || !endpoint1_enable_q
			|| shared_buffer_endpoint_select_q;
	end else if (ep_is2 && is_in) begin
		cond_stall = endpoint2_force_stall_q;
		cond_nak = !ep12_transmit_enable_q || ep12_tx_done || !endpoint2_enable_q
			|| !shared_buffer_endpoint_select_q;
	end
end

uehc_decide u_decide (
	.stall(cond_stall),
	.nak(cond_nak),
	.auto_ack(cond_auto),
	.hs(handshake)
);

// answer qualifiers; pid and count follow the addressed endpoint
assign hs_valid = tok_valid && (is_in || is_out);
assign data_pid_data1 = ep_is0 ? ep0_tx_data_pid_select_q : ep12_tx_data_pid_select_q;
assign tx_byte_count = ep_is0 ? ep0_tx_byte_count_q : ep12_tx_byte_count_q;

assign drive_k = force_remote_wakeup_q;

// ************************************
// status flags
// ************************************
// each flag: an event sets it, a written 0 clears it, set wins a tie
// endpoint 0 transmit done
uehc_flag u_tx0 (
	.clk(clk),
	.rst(rst),
	.set(host_ack_ep0),
	.clr(clr_tx0),
	.flag_q(ep0_tx_done)
);

uehc_flag u_rx0 (
	.clk(clk),
	.rst(rst),
	.set(rx_ok_ep0),
	.clr(clr_rx0),
	.flag_q(ep0_rx_done)
);

uehc_flag u_tx12 (
	.clk(clk),
	.rst(rst),
	.set(host_ack_ep12),
	.clr(clr_tx12),
	.flag_q(ep12_tx_done)
);

// own resume never sets the flag
uehc_flag u_res (
	.clk(clk),
	.rst(rst),
	.set(resume_seen),
	.clr(clr_res),
	.flag_q(resume_flag)
);

// resume flag to the outside
assign resume_detected = resume_flag;

// ************************************
// read back
// ************************************
// registered read data, unmapped reads zero;
// a cycle with no read strobe returns zero so stale data never lingers
// status bit 1 has no flag behind it in this block
always @(posedge clk) begin
	if (rst) begin
		reg_rdata_q <= `UEHC_RST_BYTE;
	end else if (reg_rd) begin
		case (reg_addr)
			`UEHC_EP0_TX_CTRL: reg_rdata_q <= {ep0_tx_data_pid_select_q, ep0_force_stall_q,
				ep0_transmit_enable_q, ep0_receive_enable_q, ep0_tx_byte_count_q};
			`UEHC_EP12_TX_CTRL: reg_rdata_q <= {ep12_tx_data_pid_select_q,
				shared_buffer_endpoint_select_q, ep12_transmit_enable_q,
				force_remote_wakeup_q, ep12_tx_byte_count_q};
			`UEHC_EP_EN_STALL: reg_rdata_q <= {3'h0, auto_status_out_reply_q,
				endpoint2_enable_q, endpoint1_enable_q, endpoint2_force_stall_q,
				endpoint1_force_stall_q};
			`UEHC_STATUS: reg_rdata_q <= {3'h0, ep0_tx_done, ep0_rx_done, ep12_tx_done,
				1'b0, resume_flag};
			default: reg_rdata_q <= `UEHC_RST_BYTE;
		endcase
	end else begin
		reg_rdata_q <= `UEHC_RST_BYTE;
	end
end

endmodule // uehc_top

// [tb/uehc_sva.sv]
// Purpose: port checks for uehc_top
// Assumes: one clock, sync reset
// Notes: shadows follow register writes
`timescale 1ns/100ps
`include "uehc_regs.vh"
module uehc_sva (
	// clock and reset
	input wire clk,
	input wire rst,
	// register writes
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	// token and answer
	input wire tok_valid,
	input wire [1:0] tok_pid,
	input wire [1:0] tok_ep,
	input wire tok_status_stage,
	input wire [1:0] handshake,
	input wire hs_valid,
	input wire data_pid_data1,
	input wire [3:0] tx_byte_count,
	input wire drive_k,
	input wire resume_detected
);
	// ****
	// token decode
	// ****
	reg [7:0] s0_q, s1_q, s2_q;
	wire tin = tok_valid && tok_pid == `UEHC_TOK_IN;
	wire in0 = tin && tok_ep == 2'h0;
	wire out0 = tok_valid && tok_pid == `UEHC_TOK_OUT && tok_ep == 2'h0;
	wire in12 = tin && tok_ep[1] != tok_ep[0];
	wire st12 = tok_ep[1] ? s2_q[1] : s2_q[0];
	// register images, setup clears ep0 stall
	always @(posedge clk) begin
		if (rst) begin
			s0_q <= 8'h00;
			s1_q <= 8'h00;
			s2_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `UEHC_EP0_TX_CTRL) s0_q <= reg_wdata;
			if (reg_wr && reg_addr == `UEHC_EP12_TX_CTRL) s1_q <= reg_wdata;
			if (reg_wr && reg_addr == `UEHC_EP_EN_STALL) s2_q <= reg_wdata;
			if (tok_valid && tok_pid == `UEHC_TOK_SETUP && tok_ep == 2'h0) s0_q[6] <= 1'b0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_EP0_STALL: assert property (s0_q[6] && (in0 || out0) |-> handshake == 2'h3)
		else $error("ep0 stall missing");
	AST_EP0_TX_NAK: assert property (in0 && !s0_q[6] && !s0_q[5] |-> handshake == 2'h2)
		else $error("ep0 in nak missing");
	AST_EP0_RX_NAK: assert property (out0 && !s0_q[6] && !s0_q[4] && !tok_status_stage
		|-> handshake == 2'h2)
		else $error("ep0 out nak missing");
	AST_AUTO_OUT: assert property (out0 && tok_status_stage && s2_q[4] && !s0_q[6]
		|-> handshake == 2'h1)
		else $error("status out not answered");
	AST_EP2_SEL: assert property (tin && tok_ep == 2'h2 && !s2_q[1] && !s1_q[6]
		|-> handshake == 2'h2)
		else $error("ep2 nak missing");
	AST_EP12_NAK: assert property (in12 && !st12 && !s1_q[5] |-> handshake == 2'h2)
		else $error("ep12 nak missing");
	AST_EP0_PID_CNT: assert property (tok_valid && tok_ep == 2'h0
		|-> {data_pid_data1, tx_byte_count} == {s0_q[7], s0_q[3:0]})
		else $error("ep0 pid or count wrong");
	AST_RESUME_K: assert property (reg_wr && reg_addr == `UEHC_EP12_TX_CTRL
		|=> drive_k == $past(reg_wdata[4]))
		else $error("k drive wrong");
	AST_NO_SELF_RESUME: assert property (drive_k |=> !$rose(resume_detected))
		else $error("self resume flagged");
	AST_HS_VALID: assert property (hs_valid == (tok_valid && tok_pid[1] == 1'b0))
		else $error("answer valid wrong");
	// main scenarios
	cover property (in0 && handshake == 2'h1);
	cover property (in12 && handshake == 2'h3);
	cover property (drive_k);
endmodule // uehc_sva
bind uehc_top uehc_sva i_sva (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .tok_valid,
	.tok_pid, .tok_ep, .tok_status_stage, .handshake, .data_pid_data1, .tx_byte_count,
	.drive_k, .resume_detected, .hs_valid);

// [tb/uehc_host.sv]
// Purpose: host and packet engine model
// Assumes: answer taken in the token cycle
// Notes: every data answer is acknowledged
`timescale 1ns/100ps
`include "uehc_regs.vh"
module uehc_host (
	// clock
	input wire clk,
	// token
	output reg tok_valid = 1'b0,
	output reg [1:0] tok_pid = 2'h3,
	output reg [1:0] tok_ep = 2'h3,
	output reg tok_status_stage = 1'b0,
	// outcomes
	output reg host_ack_ep0 = 1'b0,
	output reg host_ack_ep12 = 1'b0,
	output reg rx_ok_ep0 = 1'b0,
	output reg bus_activity = 1'b0,
	output reg suspended = 1'b0,
	// answer
	input wire [1:0] handshake,
	input wire data_pid_data1,
	input wire [3:0] tx_byte_count
);
	// ****
	// transactions
	// ****
	// one token; idle lines show inverted values
	task token(input [1:0] pid, input [1:0] ep, input ss, output [1:0] hs, output [4:0] pc);
		begin
			tok_valid <= 1'b1;
			tok_pid <= pid;
			tok_ep <= ep;
			tok_status_stage <= ss;
			@(posedge clk);
			hs = handshake;
			pc = {data_pid_data1, tx_byte_count};
			tok_valid <= 1'b0;
			tok_pid <= ~pid;
			tok_ep <= ~ep;
			tok_status_stage <= ~ss;
			if (hs == `UEHC_HS_DATA) begin
				host_ack_ep0 <= pid == `UEHC_TOK_IN && ep == 2'h0;
				host_ack_ep12 <= pid == `UEHC_TOK_IN && ep != 2'h0;
				rx_ok_ep0 <= pid == `UEHC_TOK_OUT && ep == 2'h0;
				@(posedge clk);
			end
			host_ack_ep0 <= 1'b0;
			host_ack_ep12 <= 1'b0;
			rx_ok_ep0 <= 1'b0;
			@(posedge clk);
		end
	endtask
	// bus activity pulse
	task wake(input susp);
		begin
			suspended <= susp;
			bus_activity <= 1'b1;
			@(posedge clk);
			bus_activity <= 1'b0;
			@(posedge clk);
		end
	endtask
endmodule // uehc_host

// [tb/uehc_top_tb.sv]
// Purpose: self-checking bench for uehc_top
// Assumes: 25 MHz clock, sync reset
// Notes: table rows, then hand tests
`timescale 1ns/100ps
`include "uehc_regs.vh"
module uehc_top_tb;
	reg clk, rst, reg_wr, reg_rd;
	reg [7:0] reg_addr, reg_wdata, d;
	wire [7:0] reg_rdata_q;
	wire tok_valid, tok_status_stage, host_ack_ep0, host_ack_ep12, rx_ok_ep0, bus_activity;
	wire suspended, hs_valid, data_pid_data1, drive_k, resume_detected;
	wire [1:0] tok_pid, tok_ep, handshake;
	wire [3:0] tx_byte_count;
	reg [30:0] rows [0:13];
	reg [30:0] r;
	reg [1:0] hs;
	reg [4:0] pc;
	integer i, n_errors, tests_run;
	uehc_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
		.tok_valid, .tok_pid, .tok_ep, .tok_status_stage, .host_ack_ep0, .host_ack_ep12,
		.rx_ok_ep0, .bus_activity, .suspended, .handshake, .hs_valid, .data_pid_data1,
		.tx_byte_count, .drive_k, .resume_detected);
	uehc_host i_host (.clk, .tok_valid, .tok_pid, .tok_ep, .tok_status_stage, .host_ack_ep0,
		.host_ack_ep12, .rx_ok_ep0, .bus_activity, .suspended, .handshake, .data_pid_data1,
		.tx_byte_count);
	// ****
	// helpers
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task wr(input [7:0] a, input [7:0] v);
		begin
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [7:0] a, output [7:0] v);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			@(posedge clk);
			v = reg_rdata_q;
		end
	endtask
	task chk8(input [7:0] got, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// status, unmapped and control registers all read zero
	task chk_rst;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				rd(8'hE8 + i[7:0], d);
				chk8(d, 8'h00);
			end
		end
	endtask
	task tok(input [1:0] pid, input [1:0] ep, input [1:0] exp);
		begin
			i_host.token(pid, ep, 1'b0, hs, pc);
			chk8({6'h00, hs}, {6'h00, exp});
		end
	endtask
	task test_done;
		begin
			$display("errors %0d checks %0d", n_errors, tests_run);
			if (n_errors == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// watchdog
	initial begin
		#4000000;
		n_errors = n_errors + 1;
		test_done;
	end
	// main sequence
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, n_errors, tests_run} = {3'h4, 16'h0000, 64'h0};
		// ep0 ctl, ep12 ctl, en/stall, pid, ep, status stage, answer
		rows[0] = {8'h00, 8'h00, 8'h00, 2'h1, 2'h0, 1'h0, 2'h2};
		rows[1] = {8'hA5, 8'h00, 8'h00, 2'h1, 2'h0, 1'h0, 2'h1};
		rows[2] = {8'h60, 8'h00, 8'h00, 2'h1, 2'h0, 1'h0, 2'h3};
		rows[3] = {8'h50, 8'h00, 8'h00, 2'h0, 2'h0, 1'h0, 2'h3};
		rows[4] = {8'h10, 8'h00, 8'h00, 2'h0, 2'h0, 1'h0, 2'h1};
		rows[5] = {8'h00, 8'h00, 8'h00, 2'h0, 2'h0, 1'h0, 2'h2};
		rows[6] = {8'h00, 8'h00, 8'h10, 2'h0, 2'h0, 1'h1, 2'h1};
		rows[7] = {8'h00, 8'h23, 8'h04, 2'h1, 2'h1, 1'h0, 2'h1};
		rows[8] = {8'h00, 8'h03, 8'h04, 2'h1, 2'h1, 1'h0, 2'h2};
		rows[9] = {8'h00, 8'h20, 8'h08, 2'h1, 2'h2, 1'h0, 2'h2};
		rows[10] = {8'h00, 8'hEC, 8'h08, 2'h1, 2'h2, 1'h0, 2'h1};
		rows[11] = {8'h00, 8'h60, 8'h0A, 2'h1, 2'h2, 1'h0, 2'h3};
		rows[12] = {8'h00, 8'h20, 8'h05, 2'h1, 2'h1, 1'h0, 2'h3};
		rows[13] = {8'h00, 8'h60, 8'h04, 2'h1, 2'h1, 1'h0, 2'h2};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// status, unmapped and control registers after reset
		chk_rst;
		for (i = 0; i < 14; i = i + 1) begin
			r = rows[i];
			wr(`UEHC_STATUS, 8'h00);
			wr(`UEHC_EP0_TX_CTRL, r[30:23]);
			wr(`UEHC_EP12_TX_CTRL, r[22:15]);
			wr(`UEHC_EP_EN_STALL, r[14:7]);
			i_host.token(r[6:5], r[4:3], r[2], hs, pc);
			chk8({6'h00, hs}, {6'h00, r[1:0]});
			if (r[1:0] == `UEHC_HS_DATA)
				chk8({3'h0, pc}, {3'h0, r[4:3] == 2'h0 ? {r[30], r[26:23]} : {r[22], r[18:15]}});
		end
		// done flags block repeat transfers
		wr(`UEHC_STATUS, 8'h00);
		wr(`UEHC_EP0_TX_CTRL, 8'hB0);
		tok(2'h1, 2'h0, 2'h1);
		tok(2'h0, 2'h0, 2'h1);
		tok(2'h1, 2'h0, 2'h2);
		tok(2'h0, 2'h0, 2'h2);
		rd(`UEHC_STATUS, d);
		chk8(d, 8'h18);
		rd(`UEHC_EP0_TX_CTRL, d);
		chk8(d, 8'hB0);
		wr(`UEHC_STATUS, 8'h00);
		tok(2'h1, 2'h0, 2'h1);
		// setup clears the ep0 stall
		wr(`UEHC_EP0_TX_CTRL, 8'h60);
		i_host.token(`UEHC_TOK_SETUP, 2'h0, 1'b0, hs, pc);
		rd(`UEHC_EP0_TX_CTRL, d);
		chk8(d, 8'h20);
		// shared done flag
		wr(`UEHC_STATUS, 8'h00);
		wr(`UEHC_EP12_TX_CTRL, 8'h20);
		wr(`UEHC_EP_EN_STALL, 8'h04);
		tok(2'h1, 2'h1, 2'h1);
		tok(2'h1, 2'h1, 2'h2);
		rd(`UEHC_STATUS, d);
		chk8(d, 8'h04);
		// forced resume, then real bus activity
		wr(`UEHC_STATUS, 8'h00);
		// software times the hold; the block has no timer, so it is short here
		wr(`UEHC_EP12_TX_CTRL, 8'h10);
		chk8({7'h00, drive_k}, 8'h01);
		i_host.wake(1'b1);
		chk8({7'h00, resume_detected}, 8'h00);
		wr(`UEHC_EP12_TX_CTRL, 8'h00);
		i_host.wake(1'b1);
		rd(`UEHC_STATUS, d);
		chk8(d, 8'h01);
		// reserved bits read zero, then a mid-run reset clears everything
		wr(`UEHC_EP0_TX_CTRL, 8'hFF);
		wr(`UEHC_EP12_TX_CTRL, 8'hFF);
		wr(`UEHC_EP_EN_STALL, 8'hFF);
		rd(`UEHC_EP_EN_STALL, d);
		chk8(d, 8'h1F);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk_rst;
		chk8({7'h00, drive_k}, 8'h00);
		tok(2'h1, 2'h0, 2'h2);
		test_done;
	end
endmodule // uehc_top_tb
